// ===== logic/ccsow_top.sv
// cpu clock source selection and oscillator watchdog, apb register slave
// assumes strap and crystal pin synchronous to clock
// crystal and generated clocks are levels sampled each clock
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "ccsow_defs.svh"
module ccsow_top #(
    parameter int FREE_DIV = `CCSOW_FREE_DIV
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // straps and crystal
    input  wire logic [2:0]           clock_mode_strap,
    input  wire logic                 crystal_input_pin,
    // apb slave
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // clock outputs and control
    output logic                      cpu_clk_out,
    output ccsow_pkg::ccsow_src_e     cpu_src,
    output logic                      pll_power_on,
    output logic                      osc_amp_bypass,
    output logic                      pll_ref_connected,
    output ccsow_pkg::ccsow_pll_s     pll_setting,
    // interrupt
    output logic                      irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam logic [15:0] FREE_LAST = 16'(FREE_DIV - 1);

    ccsow_pkg::ccsow_mode_e mode_r;
    ccsow_pkg::ccsow_src_e  src_r;
    ccsow_pkg::ccsow_pll_s  pll_cfg;
    logic [31:0]            syscfg_r;
    logic                   xtal_q_r;
    logic                   xtal_edge;
    logic                   xtal_rise;
    logic                   direct_like;
    logic                   owd_enabled;
    logic                   pll_on;
    logic [15:0]            free_cnt_r;
    logic                   pll_tick;
    logic [4:0]             wd_cnt_r;
    logic                   wd_active;
    logic                   wd_overflow;
    logic                   owd_fail_r;
    logic                   unlock_r;
    logic                   fail_evt;
    logic                   lock_evt;
    logic [15:0]            half_r;
    logic [15:0]            half_nxt;
    logic [15:0]            half_cnt_r;
    logic [15:0]            toggles_r;
    logic [4:0]             trans_r;
    logic [15:0]            target;
    logic                   pll_toggle;
    logic                   window_end;
    logic                   cpu_clk_r;
    logic                   cpu_clk_nxt;
    logic [`CCSOW_IRQ_W-1:0] irq_stat_r;
    logic [`CCSOW_IRQ_W-1:0] irq_mask_r;
    logic [`CCSOW_IRQ_W-1:0] irq_set;
    logic [`CCSOW_IRQ_W-1:0] irq_clr;
    logic                   wr_en;
    logic                   rd_setup;
    logic                   addr_ok;
    logic [31:0]            rd_val;
    logic [31:0]            status_val;

    // ------------------------------------------------------------------
    // strap capture and mode decode
    // ------------------------------------------------------------------
    // strap follows the pins during reset, frozen at release
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_r <= ccsow_pkg::ccsow_mode_e'(clock_mode_strap); // R17
        end
    end

    assign pll_cfg     = ccsow_pkg::pll_lookup(mode_r);
    assign direct_like = (mode_r == ccsow_pkg::MODE_DIRECT) ||
                         (mode_r == ccsow_pkg::MODE_PRESC);
    // watchdog only where the pll does not multiply
    assign owd_enabled = direct_like &&
                         !syscfg_r[`CCSOW_OWD_DIS_BIT]; // R3 R4
    // pll runs free for the watchdog, or multiplies in pll modes
    assign pll_on      = owd_enabled || !direct_like; // R2 R9 R10

    // ------------------------------------------------------------------
    // system configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            syscfg_r <= `CCSOW_SYSCFG_RST; // R3
        end else if (wr_en && paddr == `CCSOW_OFS_SYSCFG) begin
            syscfg_r <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // crystal pin transitions
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            xtal_q_r <= 1'b0;
        end else begin
            xtal_q_r <= crystal_input_pin;
        end
    end

    assign xtal_edge = crystal_input_pin ^ xtal_q_r;
    assign xtal_rise = crystal_input_pin & ~xtal_q_r;

    // ------------------------------------------------------------------
    // pll free-running clock as an enable pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || !pll_on) begin
            free_cnt_r <= 16'h0000;
        end else if (free_cnt_r == FREE_LAST) begin
            free_cnt_r <= 16'h0000;
        end else begin
            free_cnt_r <= free_cnt_r + 16'h0001;
        end
    end

    assign pll_tick = pll_on && (free_cnt_r == FREE_LAST);

    // ------------------------------------------------------------------
    // watchdog counter, also used as lock monitor in pll modes
    // ------------------------------------------------------------------
    assign wd_active   = pll_on && !owd_fail_r && !unlock_r;
    assign wd_overflow = pll_tick && !xtal_edge &&
                         (wd_cnt_r == `CCSOW_OWD_LIMIT - 5'h01); // R6

    always_ff @(posedge clock) begin
        if (reset || !wd_active) begin
            wd_cnt_r <= 5'h00;
        end else if (xtal_edge) begin
            wd_cnt_r <= 5'h00; // R5
        end else if (pll_tick) begin
            wd_cnt_r <= wd_cnt_r + 5'h01; // R5
        end
    end

    assign fail_evt = wd_overflow && owd_enabled;
    assign lock_evt = wd_overflow && !direct_like;

    // failure states hold until reset
    always_ff @(posedge clock) begin
        if (reset) begin
            owd_fail_r <= 1'b0;
        end else if (fail_evt) begin
            owd_fail_r <= 1'b1; // R7 R8
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            unlock_r <= 1'b0;
        end else if (lock_evt) begin
            unlock_r <= 1'b1; // R16
        end
    end

    // ------------------------------------------------------------------
    // pll output: half period steered per window of f transitions
    // ------------------------------------------------------------------
    assign target     = 16'(pll_cfg.factor) * 16'(pll_cfg.factor);
    assign window_end = xtal_edge && (trans_r == pll_cfg.factor - 5'h01);
    assign pll_toggle = !direct_like && (half_cnt_r >= half_r - 16'h0001);

    always_comb begin
        half_nxt = half_r;
        if (toggles_r < target && half_r > 16'h0001) begin
            half_nxt = half_r - 16'h0001;
        end else if (toggles_r > target && half_r != 16'hFFFF) begin
            half_nxt = half_r + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || direct_like) begin
            half_r <= `CCSOW_HALF_INIT;
        end else if (window_end && !unlock_r) begin
            half_r <= half_nxt; // R11
        end
    end

    always_ff @(posedge clock) begin
        if (reset || direct_like || pll_toggle) begin
            half_cnt_r <= 16'h0000;
        end else begin
            half_cnt_r <= half_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || direct_like) begin
            trans_r   <= 5'h00;
            toggles_r <= 16'h0000;
        end else if (window_end) begin
            trans_r   <= 5'h00; // R11
            toggles_r <= 16'h0000;
        end else begin
            if (xtal_edge) begin
                trans_r <= trans_r + 5'h01;
            end
            if (pll_toggle && toggles_r != 16'hFFFF) begin
                toggles_r <= toggles_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // cpu clock source selection
    // ------------------------------------------------------------------
    // the backup source is taken only while the cpu clock is low, so
    // no phase of the old source is cut short
    always_ff @(posedge clock) begin
        if (reset) begin
            src_r <= ccsow_pkg::SRC_DIRECT;
        end else if ((owd_fail_r || unlock_r) && !cpu_clk_r) begin
            src_r <= ccsow_pkg::SRC_BACKUP; // R7 R16 R18
        end else if (src_r != ccsow_pkg::SRC_BACKUP) begin
            unique case (mode_r)
                ccsow_pkg::MODE_DIRECT: src_r <= ccsow_pkg::SRC_DIRECT; // R1
                ccsow_pkg::MODE_PRESC:  src_r <= ccsow_pkg::SRC_PRESC; // R15
                default:                src_r <= ccsow_pkg::SRC_PLL; // R10
            endcase
        end
    end

    always_comb begin
        cpu_clk_nxt = cpu_clk_r;
        unique case (src_r)
            ccsow_pkg::SRC_DIRECT: cpu_clk_nxt = crystal_input_pin; // R1
            ccsow_pkg::SRC_PRESC:  begin
                if (xtal_rise) begin
                    cpu_clk_nxt = ~cpu_clk_r; // R15
                end
            end
            ccsow_pkg::SRC_PLL:    begin
                if (pll_toggle) begin
                    cpu_clk_nxt = ~cpu_clk_r; // R10
                end
            end
            ccsow_pkg::SRC_BACKUP: begin
                if (pll_tick) begin
                    cpu_clk_nxt = ~cpu_clk_r; // R8
                end
            end
        endcase
        // held low while a backup switch is pending
        if ((owd_fail_r || unlock_r) && src_r != ccsow_pkg::SRC_BACKUP &&
            !cpu_clk_r) begin
            cpu_clk_nxt = 1'b0; // R18
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cpu_clk_r <= 1'b0;
        end else begin
            cpu_clk_r <= cpu_clk_nxt;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    assign irq_set = {lock_evt, fail_evt};
    assign irq_clr = (wr_en && paddr == `CCSOW_OFS_IRQ_STAT) ?
                     pwdata[`CCSOW_IRQ_W-1:0] : '0;

    // a set in the clearing cycle wins
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set; // R7 R16
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq_mask_r <= '0;
        end else if (wr_en && paddr == `CCSOW_OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata[`CCSOW_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign addr_ok  = (paddr == `CCSOW_OFS_SYSCFG)   ||
                      (paddr == `CCSOW_OFS_STATUS)   ||
                      (paddr == `CCSOW_OFS_IRQ_STAT) ||
                      (paddr == `CCSOW_OFS_IRQ_MASK) ||
                      (paddr == `CCSOW_OFS_PLL_CFG);
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;

    assign status_val = {half_r,
                         3'h0,
                         pll_ref_connected,
                         unlock_r,
                         owd_fail_r,
                         pll_on,
                         owd_enabled,
                         2'h0,
                         src_r,
                         1'b0,
                         mode_r};

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `CCSOW_OFS_SYSCFG:   rd_val = syscfg_r;
            `CCSOW_OFS_STATUS:   rd_val = status_val;
            `CCSOW_OFS_IRQ_STAT: rd_val = 32'(irq_stat_r);
            `CCSOW_OFS_IRQ_MASK: rd_val = 32'(irq_mask_r);
            `CCSOW_OFS_PLL_CFG:  rd_val = {3'h0, pll_cfg.factor,
                                           5'h00, pll_cfg.div,
                                           1'b0, pll_cfg.mult,
                                           5'h00, pll_cfg.pre};
            default:             rd_val = 32'h0000_0000;
        endcase
    end

    // read data captured at setup, stable through access
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup && !pwrite) begin
            prdata <= rd_val;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign cpu_clk_out       = cpu_clk_r;
    assign cpu_src           = src_r;
    assign pll_power_on      = pll_on; // R9
    assign osc_amp_bypass    = (mode_r == ccsow_pkg::MODE_DIRECT); // R1
    assign pll_ref_connected = !direct_like && !unlock_r; // R16
    assign pll_setting       = pll_cfg; // R12 R13

endmodule

// ===== logic/ccsow_defs.svh
// constants of the cpu clock source and oscillator watchdog block
// included by the package and the design module
//
// Summary of operation
// [R1] strap 011 at reset: pll off, amplifier bypassed, cpu follows crystal pin; code keeps pll on while watchdog enabled
// [R2] direct or prescaler, watchdog on: pll free-runs for watchdog
// [R3] watchdog enabled after reset; setting config bit 4 disables it
// [R4] watchdog works only in direct drive or prescaler modes
// [R5] watchdog counts pll ticks, cleared by each input transition
// [R6] sixteen pll ticks without input transition mean input failed
// [R7] on failure cpu switches to pll free-running clock, interrupt flagged; code switches only at cpu clock low, not if input stops with it high
// [R8] after failure the backup clock stays until the next reset
// [R9] watchdog disabled: cpu always from oscillator, pll switched off
// [R10] every other strap enables the pll; cpu is input times factor
// [R11] pll resynchronises every f-th input transition, adjusting gradually
// [R12] straps 111,110,101,100 give 4/64/4, 4/48/4, 4/64/2, 4/40/2
// [R13] 000 gives 2/64/2 factor 16; 001 halves; 011 factor one
// [R14] system keeps pll input, vco and cpu frequencies within range
// [R15] strap 001 at reset: cpu is crystal clock through 2:1 prescaler
// [R16] pll losing lock raises interrupt and free-runs until reset
// [R17] strap latched at reset release, held until next reset
// [R18] switch to backup clock is glitch free
`ifndef CCSOW_DEFS_SVH
`define CCSOW_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CCSOW_OFS_SYSCFG   8'h00
`define CCSOW_OFS_STATUS   8'h04
`define CCSOW_OFS_IRQ_STAT 8'h08
`define CCSOW_OFS_IRQ_MASK 8'h0C
`define CCSOW_OFS_PLL_CFG  8'h10

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CCSOW_OWD_DIS_BIT  4
`define CCSOW_IRQ_OWD_BIT  0
`define CCSOW_IRQ_LOCK_BIT 1
`define CCSOW_IRQ_W        2
`define CCSOW_SYSCFG_RST   32'h0000_0000
`define CCSOW_HALF_INIT    16'h0004

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CCSOW_CLK_KHZ      25000
`define CCSOW_FREE_KHZ     1000
`define CCSOW_FREE_DIV     (`CCSOW_CLK_KHZ / `CCSOW_FREE_KHZ)
`define CCSOW_OWD_LIMIT    5'h10

`endif

// ===== logic/ccsow_pkg.sv
// types of the cpu clock source and oscillator watchdog block
// assumes the defs header beside it
`include "ccsow_defs.svh"
package ccsow_pkg;

    // clock mode strap codes
    typedef enum logic [2:0] {
        MODE_X16    = 3'b000,
        MODE_PRESC  = 3'b001,
        MODE_X10    = 3'b010,
        MODE_DIRECT = 3'b011,
        MODE_X5     = 3'b100,
        MODE_X8     = 3'b101,
        MODE_X3     = 3'b110,
        MODE_X4     = 3'b111
    } ccsow_mode_e;

    // source driving the cpu clock
    typedef enum logic [1:0] {
        SRC_DIRECT = 2'b00,
        SRC_PRESC  = 2'b01,
        SRC_PLL    = 2'b10,
        SRC_BACKUP = 2'b11
    } ccsow_src_e;

    // pll divider chain for one strap setting
    typedef struct packed {
        logic [2:0] pre;
        logic [6:0] mult;
        logic [2:0] div;
        logic [4:0] factor;
    } ccsow_pll_s;

    function automatic ccsow_pll_s pll_lookup(input ccsow_mode_e m);
        ccsow_pll_s s;
        s = '{pre: 3'h0, mult: 7'h00, div: 3'h0, factor: 5'h01};
        unique case (m)
            MODE_X4:  s = '{3'h4, 7'h40, 3'h4, 5'h04}; // R12
            MODE_X3:  s = '{3'h4, 7'h30, 3'h4, 5'h03}; // R12
            MODE_X8:  s = '{3'h4, 7'h40, 3'h2, 5'h08}; // R12
            MODE_X5:  s = '{3'h4, 7'h28, 3'h2, 5'h05}; // R12
            MODE_X10: s = '{3'h2, 7'h28, 3'h1, 5'h0A};
            MODE_X16: s = '{3'h2, 7'h40, 3'h2, 5'h10}; // R13
            MODE_PRESC, MODE_DIRECT: s = '{3'h0, 7'h00, 3'h0, 5'h01}; // R13
        endcase
        return s;
    endfunction

endpackage

// ===== tb/ccsow_top_monitor.sv
// port assertions for the cpu clock source block
// bound into ccsow_top; sees its ports only
`timescale 1ns/1ps
module ccsow_top_monitor (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  reset,
    // observed pins
    input wire logic                  crystal_input_pin,
    input wire logic                  cpu_clk_out,
    input wire ccsow_pkg::ccsow_src_e cpu_src,
    input wire logic                  pll_power_on,
    input wire logic                  osc_amp_bypass,
    input wire logic                  pll_ref_connected,
    input wire ccsow_pkg::ccsow_pll_s pll_setting
);
    logic [1:0] up_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // cycles since reset release, saturating
    always_ff @(posedge clock) begin
        if (reset)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    direct_follow_a: assert property (
        up_r == 2'h3 && cpu_src == ccsow_pkg::SRC_DIRECT
        |-> cpu_clk_out == $past(crystal_input_pin))
        else $error("direct clock mismatch");
    bypass_mode_a: assert property (
        osc_amp_bypass |-> pll_setting.factor == 5'h01
        && cpu_src != ccsow_pkg::SRC_PLL && !pll_ref_connected)
        else $error("pll used in bypass");
    pll_source_a: assert property (
        cpu_src == ccsow_pkg::SRC_PLL
        |-> pll_power_on && pll_setting.factor != 5'h01)
        else $error("pll source, pll off");
    div_chain_a: assert property (
        pll_setting.pre == 3'h4 |-> int'(pll_setting.factor) * 4
        * int'(pll_setting.div) == int'(pll_setting.mult))
        else $error("bad divider chain");
    strap_hold_a: assert property (
        !$past(reset) |-> $stable(pll_setting))
        else $error("pll setting changed");
    backup_stick_a: assert property (
        cpu_src == ccsow_pkg::SRC_BACKUP |=> cpu_src == ccsow_pkg::SRC_BACKUP)
        else $error("left backup clock");
    switch_clean_a: assert property (
        cpu_src == ccsow_pkg::SRC_BACKUP
        && $past(cpu_src) != ccsow_pkg::SRC_BACKUP |-> !$past(cpu_clk_out))
        else $error("switch while clock high");
    backup_pll_a: assert property (
        cpu_src == ccsow_pkg::SRC_BACKUP
        |-> pll_power_on && !pll_ref_connected)
        else $error("backup without pll");
    ref_lost_a: assert property (
        up_r == 2'h3 && !pll_ref_connected |=> !pll_ref_connected)
        else $error("reference reconnected");
    presc_quiet_a: assert property (
        up_r == 2'h3 && cpu_src == ccsow_pkg::SRC_PRESC
        && $stable(crystal_input_pin) [*3] |-> $stable(cpu_clk_out))
        else $error("prescaler moved idle");
endmodule

bind ccsow_top ccsow_top_monitor mon_i (
    .clock(clock), .reset(reset), .crystal_input_pin(crystal_input_pin),
    .cpu_clk_out(cpu_clk_out), .cpu_src(cpu_src),
    .pll_power_on(pll_power_on), .osc_amp_bypass(osc_amp_bypass),
    .pll_ref_connected(pll_ref_connected), .pll_setting(pll_setting)
);

// ===== tb/ccsow_xtal_model.sv
// crystal or external clock source driving the crystal pin
// runs on bench clock; a stopped source holds its level
`timescale 1ns/1ps
module ccsow_xtal_model (
    // clock and reset
    input wire logic       clock,
    input wire logic       reset,
    // control
    input wire logic       run,
    input wire logic [3:0] half,
    // crystal pin
    output logic           pin
);
    logic [3:0] cnt_r;

    // half period in bench cycles
    always_ff @(posedge clock) begin
        if (reset) begin
            pin   <= 1'b0;
            cnt_r <= 4'h1;
        end else if (run) begin
            if (cnt_r >= half) begin
                cnt_r <= 4'h1;
                pin   <= ~pin;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ===== tb/ccsow_top_tb.sv
// self-checking bench for the cpu clock source block
// drives apb and the crystal model; small free-run divider
`timescale 1ns/1ps
module ccsow_top_tb;
    localparam int FDIV = 2;
    logic clock, reset, psel, penable, pwrite, pready, pslverr;
    logic crystal_input_pin, cpu_clk_out, pll_power_on, irq;
    logic osc_amp_bypass, pll_ref_connected, run, e;
    logic [2:0] clock_mode_strap;
    logic [3:0] xhalf;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, rv;
    ccsow_pkg::ccsow_src_e cpu_src;
    ccsow_pkg::ccsow_pll_s pll_setting;
    int n_mismatch, checks_done, seed, r, t, st;
    int t_pre[8] = '{2, 0, 2, 0, 4, 4, 4, 4};
    int t_mul[8] = '{64, 0, 40, 0, 40, 64, 48, 64};
    int t_div[8] = '{2, 0, 1, 0, 2, 2, 4, 4};
    int t_fac[8] = '{16, 1, 10, 1, 5, 8, 3, 4};

    ccsow_top #(.FREE_DIV(FDIV)) DUT (
        .clock(clock), .reset(reset), .clock_mode_strap(clock_mode_strap),
        .crystal_input_pin(crystal_input_pin), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_clk_out(cpu_clk_out), .cpu_src(cpu_src),
        .pll_power_on(pll_power_on), .osc_amp_bypass(osc_amp_bypass),
        .pll_ref_connected(pll_ref_connected), .pll_setting(pll_setting),
        .irq(irq)
    );
    ccsow_xtal_model xtal (
        .clock(clock), .reset(reset), .run(run), .half(xhalf),
        .pin(crystal_input_pin)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            n_mismatch++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic [2:0] m);
        @(posedge clock);
        reset <= 1'b1;
        clock_mode_strap <= m;
        xhalf <= 4'h1 + 4'($random(seed) & 3);
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic stall(input int n);
        @(posedge clock);
        run <= 1'b0;
        repeat (n) @(posedge clock);
        run <= 1'b1;
        @(negedge clock);
    endtask

    // counts pin rises and output toggles
    task automatic count(input int n, input bit fol);
        logic lp, lc;
        r = 0;
        t = 0;
        @(negedge clock);
        lp = crystal_input_pin;
        lc = cpu_clk_out;
        repeat (n) begin
            @(negedge clock);
            if (fol) chk("direct_clk", lp, cpu_clk_out);
            if (crystal_input_pin && !lp) r++;
            if (cpu_clk_out !== lc) t++;
            lp = crystal_input_pin;
            lc = cpu_clk_out;
        end
    endtask

    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #(40 * 20000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        seed = 50;
        reset = 1'b1;
        clock_mode_strap = 3'h3;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        run = 1'b1;
        xhalf = 4'h2;
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            clock_mode_strap <= ~3'(m);
            apb(1'b0, 8'h10, 32'h0);
            chk("pll_cfg", (t_fac[m] << 24) | (t_div[m] << 16)
                | (t_mul[m] << 8) | t_pre[m], q);
            chk("pll_setting", 32'({3'(t_pre[m]), 7'(t_mul[m]),
                3'(t_div[m]), 5'(t_fac[m])}), 32'(pll_setting));
            st = (m == 3) ? 0 : (m == 1) ? 1 : 2;
            apb(1'b0, 8'h04, 32'h0);
            chk("status", 32'h200 | (st << 4) | m, q & 32'h237);
            chk("bypass", 32'(m == 3), 32'(osc_amp_bypass));
            chk("pll_on", 32'h1, 32'(pll_power_on));
            apb(1'b0, 8'h00, 32'h0);
            chk("syscfg", 32'h0, q);
        end
        do_reset(3'h1);
        count(120, 1'b0);
        chk("presc_edges", 1, 32'(r > 0 && $unsigned(t - r + 1) < 3));
        do_reset(3'h3);
        count(40, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        chk("unmapped", 32'h0, q);
        rv = $random(seed);
        apb(1'b1, 8'h0C, rv);
        apb(1'b0, 8'h0C, 32'h0);
        chk("irq_mask", rv & 32'h3, q & 32'h3);
        apb(1'b1, 8'h0C, 32'h1);
        stall(20);
        apb(1'b0, 8'h08, 32'h0);
        chk("no_fail", 32'h0, q & 32'h3);
        stall(60);
        apb(1'b0, 8'h08, 32'h0);
        chk("owd_fail", 32'h1, q & 32'h3);
        chk("irq_set", 32'h1, 32'(irq));
        chk("src_backup", 32'(ccsow_pkg::SRC_BACKUP), 32'(cpu_src));
        run <= 1'b0;
        count(40, 1'b0);
        chk("backup_clk", 1, 32'($unsigned(t - 40 / FDIV + 1) < 3));
        run <= 1'b1;
        count(20, 1'b0);
        chk("stay_backup", 32'(ccsow_pkg::SRC_BACKUP), 32'(cpu_src));
        apb(1'b1, 8'h0C, 32'h0);
        @(negedge clock);
        chk("irq_masked", 32'h0, 32'(irq));
        apb(1'b1, 8'h0C, 32'h1);
        @(negedge clock);
        chk("irq_unmasked", 32'h1, 32'(irq));
        apb(1'b1, 8'h08, 32'h1);
        @(negedge clock);
        chk("irq_cleared", 32'h0, 32'(irq));
        do_reset(3'h3);
        chk("src_restored", 32'(ccsow_pkg::SRC_DIRECT), 32'(cpu_src));
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b0, 8'h00, 32'h0);
        chk("owd_dis", 32'h10, q & 32'h10);
        chk("pll_off", 32'h0, 32'(pll_power_on));
        stall(60);
        apb(1'b0, 8'h08, 32'h0);
        chk("dis_no_fail", 32'h0, q & 32'h3);
        chk("dis_src", 32'(ccsow_pkg::SRC_DIRECT), 32'(cpu_src));
        do_reset(3'h7);
        chk("ref_on", 32'h1, 32'(pll_ref_connected));
        stall(60);
        apb(1'b0, 8'h08, 32'h0);
        chk("unlock", 32'h2, q & 32'h3);
        chk("ref_off", 32'h0, 32'(pll_ref_connected));
        finish_test();
    end
endmodule
